// ### verilog/btrr_pkg.sv
// Shared constants for the branch trace RAM recorder.
// Assumes one platform clock; every file imports the whole package.
package btrr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // RAM array geometry
  localparam int RAM_WORDS = 256;
  localparam int RAM_AW = 8;
  localparam int BYTE_AW = 10;
  localparam int DATA_W = 32;
  localparam int PC_W = 31;

  ////////////////////////////////////////////////////////////////////////////////
  // Packet layout
  localparam logic [BYTE_AW-1:0] PKT_BYTES = 10'h008;
  localparam int FLAG_BIT = 0;
  localparam int WORD_SEL_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // AHB encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator actions
  localparam int NUM_CMP = 2;
  localparam logic [1:0] CMP_OFF = 2'h0;
  localparam logic [1:0] CMP_START = 2'h1;
  localparam logic [1:0] CMP_STOP = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [BYTE_AW-1:0] POS_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_RESET = 31'h00000000;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h00000000;

  typedef enum logic [1:0] {BTRR_IDLE, BTRR_WORD0, BTRR_WORD1} btrr_state_t;

endpackage

// ### verilog/btrr_ram.sv
// Single-port RAM array built from flip-flops, with byte write enables.
// Assumes the controller gives it one access per cycle; read is combinational.
`timescale 1ns/1ps
`default_nettype none
module btrr_ram
  import btrr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Access port
  input wire logic i_we,
  input wire logic [3:0] i_be,
  input wire logic [RAM_AW-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata
);

  logic [DATA_W-1:0] mem_reg [RAM_WORDS];

  ////////////////////////////////////////////////////////////////////////////////
  // One flop word per entry
  genvar gi;
  generate
    for (gi = 0; gi < RAM_WORDS; gi++)
    begin : g_word
      logic [DATA_W-1:0] word_next;
      always_comb
      begin
        word_next = mem_reg[gi];
        if (i_we && (i_addr == RAM_AW'(gi)))
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (i_be[b])
            begin
              word_next[b*8 +: 8] = i_wdata[b*8 +: 8];
            end
          end
        end
      end
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          mem_reg[gi] <= WORD_RESET;
        end
        else
        begin
          mem_reg[gi] <= word_next;
        end
      end
    end
  endgenerate

  assign o_rdata = mem_reg[i_addr];

endmodule
`default_nettype wire

// ### verilog/btrr_watch.sv
// Watchpoint block: two comparators that start or stop recording.
// Assumes the monitored bus and the settings are on the platform clock.
`timescale 1ns/1ps
`default_nettype none
module btrr_watch
  import btrr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Comparator settings
  input wire logic [NUM_CMP-1:0][DATA_W-1:0] i_cmp_addr,
  input wire logic [NUM_CMP-1:0][DATA_W-1:0] i_cmp_data,
  input wire logic [NUM_CMP-1:0] i_cmp_use_data,
  input wire logic [NUM_CMP-1:0][1:0] i_cmp_action,
  // Monitored bus
  input wire logic i_mon_valid,
  input wire logic [DATA_W-1:0] i_mon_addr,
  input wire logic [DATA_W-1:0] i_mon_data,
  // Recording control
  output logic o_record_begin,
  output logic o_record_end
);

  logic [NUM_CMP-1:0] hit;
  logic begin_reg;
  logic begin_next;
  logic end_reg;
  logic end_next;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++)
    begin : g_cmp
      assign hit[gi] = i_mon_valid && (i_mon_addr == i_cmp_addr[gi]) &&
                       (!i_cmp_use_data[gi] || (i_mon_data == i_cmp_data[gi])); // RULE18
    end
  endgenerate

  always_comb
  begin
    begin_next = 1'b0;
    end_next = 1'b0;
    for (int c = 0; c < NUM_CMP; c++)
    begin
      if (hit[c] && (i_cmp_action[c] == CMP_START))
      begin
        begin_next = 1'b1; // RULE18
      end
      if (hit[c] && (i_cmp_action[c] == CMP_STOP))
      begin
        end_next = 1'b1; // RULE18
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      begin_reg <= 1'b0;
      end_reg <= 1'b0;
    end
    else
    begin
      begin_reg <= begin_next;
      end_reg <= end_next;
    end
  end

  assign o_record_begin = begin_reg;
  assign o_record_end = end_reg;

endmodule
`default_nettype wire

// ### verilog/btrr_top.sv
// Function
// RULE1: one two-word packet per non-sequential program counter change.
// RULE2: first word at even word: source bits 31..1, origin flag in bit 0.
// RULE3: origin flag clear for program branch, set for exception or debug update.
// RULE4: second word at odd word: destination bits 31..1, session-first flag bit 0.
// RULE5: session-first flag only in first packet after each recording start.
// RULE6: flag set means source is preferred return address, else branch address.
// RULE7: exception return first packet: return instruction to return code, flag clear.
// RULE8: exception return second packet: return code to resume address, flag set.
// RULE9: RAM served to bus reads and writes and to trace packet writes.
// RULE10: bus accesses complete with no wait states when no trace write.
// RULE11: hold two address phases and one write data beat while RAM busy.
// RULE12: system side is a 32-bit AHB slave on a crossbar port.
// RULE13: core drives lockup low when running, high each lockup cycle.
// RULE14: core flags sequential next address and pulses address load enable.
// RULE15: core supplies registered execute address as program counter over two.
// RULE16: core flags non-program activity while it is doing such activity.
// RULE17: halt request output asks the core to enter debug and halt.
// RULE18: two comparators, address or address plus data, start and stop recording.
// RULE19: everything runs on the one platform clock.
// RULE20: no special modes; bus served purely by address.
// RULE21: trace region base and size set by software.
// RULE22: packets take eight bytes each, stored one after another.
// RULE23: writable write pointer with wrap flag, advanced per packet.
// RULE24: trace write wins a collision; bus access gets wait states.
// RULE25: pointer steps eight bytes, wraps to region base at region end.
//
// Top of the recorder: AHB slave, trace packet writer, RAM and watch unit.
// Assumes all inputs are on i_clk; settings come from a register block outside.
`timescale 1ns/1ps
`default_nettype none
module btrr_top
  import btrr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AHB slave
  input wire logic i_hsel,
  input wire logic [DATA_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [DATA_W-1:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [DATA_W-1:0] o_hrdata,
  // Core execution trace port
  input wire logic i_lockup,
  input wire logic i_exec_addr_sequential,
  input wire logic i_exec_addr_load,
  input wire logic [PC_W-1:0] i_exec_pc_half,
  input wire logic i_non_program_activity,
  output logic o_halt_request,
  // Trace settings
  input wire logic i_record_enable,
  input wire logic i_halt_on_wrap,
  input wire logic [BYTE_AW-1:0] i_region_base,
  input wire logic [BYTE_AW-1:0] i_region_end,
  input wire logic i_pos_write,
  input wire logic [BYTE_AW-1:0] i_pos_wdata,
  input wire logic i_wrap_wdata,
  output logic [BYTE_AW-1:0] o_pos,
  output logic o_wrap,
  output logic o_recording,
  output logic o_packet_drop,
  // Watch settings and monitored bus
  input wire logic [NUM_CMP-1:0][DATA_W-1:0] i_cmp_addr,
  input wire logic [NUM_CMP-1:0][DATA_W-1:0] i_cmp_data,
  input wire logic [NUM_CMP-1:0] i_cmp_use_data,
  input wire logic [NUM_CMP-1:0][1:0] i_cmp_action,
  input wire logic i_mon_valid,
  input wire logic [DATA_W-1:0] i_mon_addr,
  input wire logic [DATA_W-1:0] i_mon_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic record_begin;
  logic record_end;
  logic ram_we;
  logic [3:0] ram_be;
  logic [RAM_AW-1:0] ram_addr;
  logic [DATA_W-1:0] ram_wdata;
  logic [DATA_W-1:0] ram_rdata;
  logic addr_phase;
  logic trace_busy;
  logic stall;
  logic [3:0] be_dec;
  logic dp_valid_reg, dp_valid_next;
  logic dp_write_reg, dp_write_next;
  logic [RAM_AW-1:0] dp_addr_reg, dp_addr_next;
  logic [3:0] dp_be_reg, dp_be_next;
  logic wbuf_valid_reg, wbuf_valid_next;
  logic [DATA_W-1:0] wbuf_reg, wbuf_next;
  btrr_state_t state_reg, state_next;
  logic [PC_W-1:0] last_pc_reg, last_pc_next;
  logic new_pkt;
  logic [DATA_W-1:0] new_w0;
  logic [DATA_W-1:0] new_w1;
  logic [DATA_W-1:0] cur_w0_reg, cur_w0_next;
  logic [DATA_W-1:0] cur_w1_reg, cur_w1_next;
  logic pend_valid_reg, pend_valid_next;
  logic [DATA_W-1:0] pend_w0_reg, pend_w0_next;
  logic [DATA_W-1:0] pend_w1_reg, pend_w1_next;
  logic drop_reg, drop_next;
  logic rec_reg, rec_next;
  logic first_reg, first_next;
  logic [BYTE_AW-1:0] pos_reg, pos_next;
  logic [BYTE_AW-1:0] pos_step;
  logic wrap_reg, wrap_next;
  logic wrap_event;
  logic halt_reg, halt_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules
  btrr_watch u_watch (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_cmp_addr(i_cmp_addr),
    .i_cmp_data(i_cmp_data),
    .i_cmp_use_data(i_cmp_use_data),
    .i_cmp_action(i_cmp_action),
    .i_mon_valid(i_mon_valid),
    .i_mon_addr(i_mon_addr),
    .i_mon_data(i_mon_data),
    .o_record_begin(record_begin),
    .o_record_end(record_end)
  );

  btrr_ram u_ram (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_we(ram_we),
    .i_be(ram_be),
    .i_addr(ram_addr),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // AHB address and data phases
  // Every address hits the RAM; upper bits alias, so no error response exists
  assign addr_phase = i_hsel && i_htrans[HTRANS_ACTIVE_BIT] && i_hready; // RULE12 RULE20
  assign trace_busy = (state_reg != BTRR_IDLE);
  assign stall = dp_valid_reg && trace_busy; // RULE24
  assign o_hreadyout = !stall; // RULE10
  assign o_hresp = HRESP_OKAY;
  assign o_hrdata = ram_rdata;

  always_comb
  begin
    if (i_hsize == HSIZE_BYTE)
    begin
      be_dec = 4'h1 << i_haddr[1:0];
    end
    else if (i_hsize == HSIZE_HALF)
    begin
      be_dec = i_haddr[1] ? 4'hc : 4'h3;
    end
    else
    begin
      be_dec = 4'hf;
    end
  end

  always_comb
  begin
    dp_valid_next = dp_valid_reg;
    dp_write_next = dp_write_reg;
    dp_addr_next = dp_addr_reg;
    dp_be_next = dp_be_reg;
    wbuf_valid_next = wbuf_valid_reg;
    wbuf_next = wbuf_reg;
    // Data phase held while stalled; master holds the next address phase
    if (i_hready)
    begin
      dp_valid_next = addr_phase; // RULE11
      dp_write_next = i_hwrite;
      dp_addr_next = i_haddr[BYTE_AW-1:2];
      dp_be_next = be_dec;
      wbuf_valid_next = 1'b0;
    end
    else if (stall && dp_write_reg && !wbuf_valid_reg)
    begin
      wbuf_valid_next = 1'b1; // RULE11
      wbuf_next = i_hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // RAM port arbitration
  always_comb
  begin
    ram_we = 1'b0;
    ram_be = 4'hf;
    ram_addr = dp_addr_reg;
    ram_wdata = wbuf_valid_reg ? wbuf_reg : i_hwdata;
    if (state_reg == BTRR_WORD0)
    begin
      ram_we = 1'b1; // RULE24 RULE9
      ram_addr = pos_reg[BYTE_AW-1:2]; // RULE2
      ram_wdata = cur_w0_reg;
    end
    else if (state_reg == BTRR_WORD1)
    begin
      ram_we = 1'b1;
      ram_addr = pos_reg[BYTE_AW-1:2] | RAM_AW'(1 << WORD_SEL_BIT); // RULE4
      ram_wdata = cur_w1_reg;
    end
    else if (dp_valid_reg && dp_write_reg)
    begin
      ram_we = 1'b1; // RULE9
      ram_be = dp_be_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Packet capture from the execution trace port
  // The core steps through the return code as its own address, so an
  // exception return yields both packets from this one path
  assign new_pkt = i_exec_addr_load && !i_exec_addr_sequential && rec_reg && !i_lockup; // RULE1
  assign new_w0 = {last_pc_reg, i_non_program_activity}; // RULE2 RULE3 RULE6 RULE7 RULE8
  assign new_w1 = {i_exec_pc_half, first_reg}; // RULE4 RULE5 RULE7 RULE8

  always_comb
  begin
    last_pc_next = last_pc_reg;
    if (i_exec_addr_load)
    begin
      last_pc_next = i_exec_pc_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Recording state and session-first flag
  always_comb
  begin
    rec_next = rec_reg;
    if (!i_record_enable)
    begin
      rec_next = 1'b0;
    end
    else if (record_begin)
    begin
      rec_next = 1'b1; // RULE18
    end
    else if (record_end)
    begin
      rec_next = 1'b0;
    end
    first_next = first_reg;
    if (new_pkt)
    begin
      first_next = 1'b0; // RULE5
    end
    if (rec_next && !rec_reg)
    begin
      first_next = 1'b1; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Packet writer: word 0 then word 1, one packet waiting behind
  // A third packet arriving in word 0 while two are held is dropped and flagged
  always_comb
  begin
    state_next = state_reg;
    cur_w0_next = cur_w0_reg;
    cur_w1_next = cur_w1_reg;
    pend_valid_next = pend_valid_reg;
    pend_w0_next = pend_w0_reg;
    pend_w1_next = pend_w1_reg;
    drop_next = 1'b0;
    case (state_reg)
      BTRR_IDLE:
      begin
        if (new_pkt)
        begin
          cur_w0_next = new_w0;
          cur_w1_next = new_w1;
          state_next = BTRR_WORD0;
        end
      end
      BTRR_WORD0:
      begin
        state_next = BTRR_WORD1;
        if (new_pkt)
        begin
          if (pend_valid_reg)
          begin
            drop_next = 1'b1;
          end
          else
          begin
            pend_valid_next = 1'b1;
            pend_w0_next = new_w0;
            pend_w1_next = new_w1;
          end
        end
      end
      BTRR_WORD1:
      begin
        state_next = BTRR_IDLE;
        if (pend_valid_reg)
        begin
          cur_w0_next = pend_w0_reg;
          cur_w1_next = pend_w1_reg;
          state_next = BTRR_WORD0;
          pend_valid_next = new_pkt;
          pend_w0_next = new_w0;
          pend_w1_next = new_w1;
        end
        else if (new_pkt)
        begin
          cur_w0_next = new_w0;
          cur_w1_next = new_w1;
          state_next = BTRR_WORD0;
        end
      end
      default:
      begin
        state_next = BTRR_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write pointer, wrap flag and halt request
  assign pos_step = pos_reg + PKT_BYTES; // RULE22 RULE25
  assign wrap_event = (state_reg == BTRR_WORD1) && (pos_step >= i_region_end); // RULE21

  always_comb
  begin
    pos_next = pos_reg;
    wrap_next = wrap_reg;
    if (state_reg == BTRR_WORD1)
    begin
      pos_next = wrap_event ? i_region_base : pos_step; // RULE23 RULE25
    end
    if (i_pos_write)
    begin
      pos_next = i_pos_wdata; // RULE23
      wrap_next = i_wrap_wdata;
    end
    if (wrap_event)
    begin
      wrap_next = 1'b1; // RULE23
    end
    halt_next = i_halt_on_wrap && wrap_next; // RULE17
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge i_clk or negedge i_rst_n) // RULE19
  begin
    if (!i_rst_n)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= '0;
      dp_be_reg <= 4'h0;
      wbuf_valid_reg <= 1'b0;
      wbuf_reg <= WORD_RESET;
      state_reg <= BTRR_IDLE;
      last_pc_reg <= PC_RESET;
      cur_w0_reg <= WORD_RESET;
      cur_w1_reg <= WORD_RESET;
      pend_valid_reg <= 1'b0;
      pend_w0_reg <= WORD_RESET;
      pend_w1_reg <= WORD_RESET;
      drop_reg <= 1'b0;
      rec_reg <= 1'b0;
      first_reg <= 1'b0;
      pos_reg <= POS_RESET;
      wrap_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else
    begin
      dp_valid_reg <= dp_valid_next;
      dp_write_reg <= dp_write_next;
      dp_addr_reg <= dp_addr_next;
      dp_be_reg <= dp_be_next;
      wbuf_valid_reg <= wbuf_valid_next;
      wbuf_reg <= wbuf_next;
      state_reg <= state_next;
      last_pc_reg <= last_pc_next;
      cur_w0_reg <= cur_w0_next;
      cur_w1_reg <= cur_w1_next;
      pend_valid_reg <= pend_valid_next;
      pend_w0_reg <= pend_w0_next;
      pend_w1_reg <= pend_w1_next;
      drop_reg <= drop_next;
      rec_reg <= rec_next;
      first_reg <= first_next;
      pos_reg <= pos_next;
      wrap_reg <= wrap_next;
      halt_reg <= halt_next;
    end
  end

  assign o_pos = pos_reg;
  assign o_wrap = wrap_reg;
  assign o_recording = rec_reg;
  assign o_packet_drop = drop_reg;
  assign o_halt_request = halt_reg;

endmodule
`default_nettype wire

// ### test/btrr_properties.sv
// Checker for the recorder top: bus answer, pointer and recording relations.
// Assumes one clock and that it is bound to btrr_top.
`timescale 1ns/1ps
`default_nettype none
module btrr_properties
  import btrr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched inputs
  input wire logic i_lockup,
  input wire logic i_exec_addr_sequential,
  input wire logic i_exec_addr_load,
  input wire logic i_pos_write,
  input wire logic [BYTE_AW-1:0] i_pos_wdata,
  input wire logic [BYTE_AW-1:0] i_region_base,
  input wire logic i_halt_on_wrap,
  input wire logic i_record_enable,
  // Watched outputs
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [BYTE_AW-1:0] o_pos,
  input wire logic o_wrap,
  input wire logic o_recording,
  input wire logic o_halt_request
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Cycles since the last captured branch, saturating
  logic cap;
  logic [3:0] since_reg;
  logic [3:0] since_next;
  assign cap = i_exec_addr_load && !i_exec_addr_sequential && o_recording && !i_lockup;
  always_comb
  begin
    since_next = since_reg;
    if (cap)
      since_next = 4'h0;
    else if (since_reg != 4'hf)
      since_next = since_reg + 4'h1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      since_reg <= 4'hf;
    else
      since_reg <= since_next;
  end

  ////////////////////////////////////////
  resp_okay_a: assert property (o_hresp == HRESP_OKAY)
    else $error("bus response not okay");
  zero_wait_a: assert property (!o_hreadyout |-> since_reg <= 4'h6)
    else $error("wait state with no trace write");
  stall_end_a: assert property ($fell(o_hreadyout) |-> ##[1:6] o_hreadyout)
    else $error("bus stall too long");
  pos_step_a: assert property (cap && since_reg > 4'h5 && !i_pos_write |-> ##3
    (o_pos == $past(o_pos, 3) + PKT_BYTES || o_pos == $past(i_region_base, 3)))
    else $error("pointer did not step one packet");
  pos_cause_a: assert property ($changed(o_pos) && !$past(i_pos_write) |->
    $past(since_reg) <= 4'h5)
    else $error("pointer moved without a packet");
  wrap_base_a: assert property ($rose(o_wrap) && !$past(i_pos_write) |->
    o_pos == $past(i_region_base))
    else $error("wrap without return to base");
  pos_load_a: assert property (i_pos_write |=> o_pos == $past(i_pos_wdata))
    else $error("pointer write lost");
  halt_wrap_a: assert property (o_halt_request == ($past(i_halt_on_wrap) && o_wrap))
    else $error("halt request wrong");
  gate_off_a: assert property (!i_record_enable |=> !o_recording)
    else $error("recording while disabled");
  rec_rise_a: assert property ($rose(o_recording) |-> $past(i_record_enable))
    else $error("recording began while disabled");

  cover property (cap);
  cover property (!o_hreadyout);
  cover property ($rose(o_wrap));
  cover property ($fell(o_recording));
endmodule

bind btrr_top btrr_properties u_props (
  .i_clk, .i_rst_n, .i_lockup, .i_exec_addr_sequential, .i_exec_addr_load,
  .i_pos_write, .i_pos_wdata, .i_region_base, .i_halt_on_wrap, .i_record_enable,
  .o_hreadyout, .o_hresp, .o_pos, .o_wrap, .o_recording, .o_halt_request
);
`default_nettype wire

// ### test/btrr_core_model.sv
// Behavioural model of the core's execution trace port.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module btrr_core_model
  import btrr_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Trace port
  output logic o_lockup,
  output logic o_seq,
  output logic o_load,
  output logic [PC_W-1:0] o_pc_half,
  output logic o_npa
);
  initial
  begin
    o_lockup = 1'b0;
    o_seq = 1'b0;
    o_load = 1'b0;
    o_pc_half = PC_RESET;
    o_npa = 1'b0;
  end

  // One address load; lk models a load seen during lockup
  task step(input logic [PC_W-1:0] pc, input logic sq, np, lk);
    o_pc_half = pc;
    o_seq = sq;
    o_npa = np;
    o_lockup = lk;
    o_load = 1'b1;
    @(posedge i_clk);
    #1;
  endtask

  // Quiet cycles; sequence flag toggles since it means nothing without a load
  task rest(input int n);
    o_load = 1'b0;
    o_lockup = 1'b0;
    repeat (n)
    begin
      o_seq = ~o_seq;
      @(posedge i_clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// ### test/test_btrr_top.sv
// Self-checking bench for the recorder top with a core model on the trace port.
// Assumes the checker is bound by its own file; bus reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module test_btrr_top
  import btrr_pkg::*;
;
  logic clk, rst_n, hsel, hwrite, rec_en, halt_wrap, pos_wr, wrap_wd, mon_valid;
  logic hreadyout, hresp, lockup, seq, load, npa, halt, wrap, rec, drop, rdp, first;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DATA_W-1:0] haddr, hwdata, mon_addr, mon_data, hrdata, rnd;
  logic [BYTE_AW-1:0] base, rend, pos_wd, pos;
  logic [NUM_CMP-1:0][DATA_W-1:0] cmp_addr, cmp_data;
  logic [NUM_CMP-1:0] cmp_use;
  logic [NUM_CMP-1:0][1:0] cmp_act;
  logic [PC_W-1:0] pc_half, prev;
  logic [DATA_W-1:0] ew [16];
  logic [DATA_W-1:0] exp_q [$];
  int failures, samples_checked, ne;

  always #5 clk = ~clk;

  btrr_core_model core (.i_clk(clk), .o_lockup(lockup), .o_seq(seq), .o_load(load),
    .o_pc_half(pc_half), .o_npa(npa));
  btrr_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_lockup(lockup), .i_exec_addr_sequential(seq), .i_exec_addr_load(load),
    .i_exec_pc_half(pc_half), .i_non_program_activity(npa), .o_halt_request(halt),
    .i_record_enable(rec_en), .i_halt_on_wrap(halt_wrap), .i_region_base(base),
    .i_region_end(rend), .i_pos_write(pos_wr), .i_pos_wdata(pos_wd), .i_wrap_wdata(wrap_wd),
    .o_pos(pos), .o_wrap(wrap), .o_recording(rec), .o_packet_drop(drop),
    .i_cmp_addr(cmp_addr), .i_cmp_data(cmp_data), .i_cmp_use_data(cmp_use),
    .i_cmp_action(cmp_act), .i_mon_valid(mon_valid), .i_mon_addr(mon_addr),
    .i_mon_data(mon_data));

  ////////////////////////////////////////
  task chk(input logic [DATA_W-1:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_rd(input logic [DATA_W-1:0] got);
    if (exp_q.size() == 0)
      chk(got, ~got);
    else
      chk(got, exp_q.pop_front());
  endtask

  task close_out;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [DATA_W-1:0] nxt(input logic [DATA_W-1:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Negedge view: hreadyout is settled and holds to the next edge
  always @(negedge clk)
  begin
    if (rdp && hreadyout)
      chk_rd(hrdata);
    if (hreadyout)
      rdp = hsel && htrans[1] && !hwrite;
  end

  // One transfer; address held until taken, data held until the beat ends
  task ahb(input logic w, input logic [2:0] sz, input logic [DATA_W-1:0] a, d);
    if (!w)
      exp_q.push_back(d);
    hsel = 1'b1;
    htrans = 2'h2;
    hwrite = w;
    hsize = sz;
    haddr = a;
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    @(posedge clk);
    #1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwdata = d;
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    @(posedge clk);
    #1;
  endtask

  task mon(input logic [DATA_W-1:0] a, d);
    mon_valid = 1'b1;
    mon_addr = a;
    mon_data = d;
    @(posedge clk);
    #1;
    mon_valid = 1'b0;
  endtask

  task wait_rec(input logic v);
    int n;
    n = 0;
    while (rec !== v && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(rec), 32'(v));
  endtask

  // Address load with a bus read racing the packet writes
  task ld(input logic [PC_W-1:0] pc, input logic sq, np);
    if (!sq)
    begin
      ew[ne] = {prev, np};
      ew[ne + 1] = {pc, first};
      ne = ne + 2;
      first = 1'b0;
    end
    prev = pc;
    core.step(pc, sq, np, 1'b0);
    fork
      core.rest(4);
      ahb(1'b0, 3'h2, 32'h00000040, 32'h5566aa44);
    join
  endtask

  task rd_pkts(input int n);
    for (int i = 0; i < n; i++)
      ahb(1'b0, 3'h2, 32'(base) + 32'(4 * i), ew[i]);
  endtask

  initial
  begin
    #50us;
    failures++;
    close_out;
  end

  initial
  begin
    {clk, rst_n, hsel, hwrite, pos_wr, wrap_wd, mon_valid, rdp, first} = 9'h000;
    {htrans, hsize, haddr, hwdata, mon_addr, mon_data, pos_wd, prev} = '0;
    rnd = 32'h0000005b;
    failures = 0;
    samples_checked = 0;
    ne = 0;
    base = 10'h100;
    rend = 10'h120;
    rec_en = 1'b1;
    halt_wrap = 1'b1;
    cmp_addr = {32'h20000080, 32'h20000040};
    cmp_data = {32'h5a5a1234, 32'h00000000};
    cmp_use = 2'h2;
    cmp_act = {CMP_STOP, CMP_START};
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    ahb(1'b1, 3'h2, 32'h00000040, 32'h11223344);
    ahb(1'b1, HSIZE_BYTE, 32'h00000041, 32'h0000aa00);
    ahb(1'b1, HSIZE_HALF, 32'h00000042, 32'h55660000);
    ahb(1'b0, 3'h2, 32'h00000440, 32'h5566aa44);
    $display("bus test done");
    pos_wr = 1'b1;
    pos_wd = base;
    @(posedge clk);
    #1;
    pos_wr = 1'b0;
    chk(32'(pos), 32'(base));
    mon(cmp_addr[0], rnd);
    wait_rec(1'b1);
    first = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      rnd = nxt(rnd);
      ld(rnd[30:0], 1'b1, 1'b0);
      rnd = nxt(rnd);
      if (k < 2)
        ld(rnd[30:0], 1'b0, k[0]);
    end
    ld(31'h7ffffffc, 1'b0, 1'b0);
    ld(rnd[30:0], 1'b0, 1'b1);
    chk(32'(pos), 32'(base));
    chk(32'(wrap), 32'h1);
    chk(32'(halt), 32'h1);
    rd_pkts(8);
    $display("trace test done");
    mon(cmp_addr[1], ~cmp_data[1]);
    repeat (4) @(posedge clk);
    #1;
    chk(32'(rec), 32'h1);
    mon(cmp_addr[1], cmp_data[1]);
    wait_rec(1'b0);
    mon(cmp_addr[0], rnd);
    wait_rec(1'b1);
    first = 1'b1;
    ne = 0;
    core.step(prev, 1'b0, 1'b0, 1'b1);
    core.rest(4);
    chk(32'(pos), 32'(base));
    rnd = nxt(rnd);
    ld(rnd[30:0], 1'b1, 1'b0);
    rnd = nxt(rnd);
    ld(rnd[30:0], 1'b0, 1'b0);
    chk(32'(pos), 32'(base) + 32'h8);
    rd_pkts(2);
    // Four branches in a row overflow the one waiting slot; a stalled write parks its data
    fork
      begin
        for (int k = 0; k < 4; k++)
          core.step(31'(k), 1'b0, 1'b0, 1'b0);
        chk(32'(drop), 32'h1);
        core.rest(4);
      end
      ahb(1'b1, 3'h2, 32'h00000044, 32'h0badf00d);
    join
    ahb(1'b0, 3'h2, 32'h00000044, 32'h0badf00d);
    rec_en = 1'b0;
    @(posedge clk);
    #1;
    chk(32'(rec), 32'h0);
    $display("restart test done");
    close_out;
  end
endmodule
`default_nettype wire
